// *** rtl/sent_nibble_link.sv ***
// single-wire falling-edge nibble link, transmitter or receiver
// assumes all inputs synchronous to clk except rxLine, which is synchronised here
`default_nettype none

module sent_nibble_link #(
	parameter int CNT_W = 22
) (
	// clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// configuration
	input wire logic enable,
	input wire logic receiveMode,
	input wire logic syncTransmit,
	input wire logic crcHardware,
	input wire logic pauseEnable,
	input wire logic [2:0] nibbleCount,
	input wire logic [15:0] link_control_two,
	input wire logic [15:0] frameTicks,
	// transmit buffer
	input wire logic [3:0] txStatus,
	input wire logic [23:0] txData,
	input wire logic [3:0] txCrc,
	input wire logic syncTrigger,
	// transmit status
	output logic txLine,
	output logic txBusy,
	output logic txFrameDone,
	// receive line
	input wire logic rxLine,
	// receive buffer and events
	output logic [3:0] rxStatus,
	output logic [23:0] rxData,
	output logic [3:0] rxCrc,
	output logic [CNT_W-1:0] rxSyncClocks,
	output logic rxDone,
	output logic rxCrcError,
	output logic rxFramingError
);
	localparam int PW = 30;

	crc_step_if crcBus ();

	nibble_crc crcEngine (
		.clk(clk),
		.reset_n(reset_n),
		.crcBus(crcBus)
	);

	logic [15:0] tick_period_count;
	assign tick_period_count = link_control_two;

	// role selection; reset keeps receiveMode low by convention
	logic txOn;
	logic rxOn;
	assign txOn = enable && !receiveMode;
	assign rxOn = enable && receiveMode;

	logic [2:0] nibLast;
	always_comb begin
		if (nibbleCount < sent_pkg::NIB_COUNT_MIN) begin
			nibLast = sent_pkg::NIB_COUNT_MIN - 3'h1;
		end else if (nibbleCount > sent_pkg::NIB_COUNT_MAX) begin
			nibLast = sent_pkg::NIB_COUNT_MAX - 3'h1;
		end else begin
			nibLast = nibbleCount - 3'h1;
		end
	end

	// ---------------- transmit ----------------
	sent_pkg::tx_state_t txState;
	logic [15:0] tickDiv;
	logic tickEn;
	logic [9:0] tickCnt;
	logic [9:0] intervalLen;
	logic [10:0] usedTicks;
	logic [10:0] doneTicks;
	logic [2:0] txIdx;
	logic [3:0] shadowStatus;
	logic [23:0] shadowData;
	logic [3:0] shadowCrc;
	logic triggerPending;
	logic txStart;
	logic lastTick;
	logic [9:0] pauseLen;
	logic txCrcClear;
	logic txCrcStep;
	logic [3:0] txCrcNib;

	function automatic logic [3:0] pickNibble(input logic [23:0] d, input logic [2:0] k);
		pickNibble = d[4 * (5 - int'(k)) +: 4];
	endfunction : pickNibble

	function automatic logic [9:0] nibTicks(input logic [3:0] v);
		nibTicks = sent_pkg::NIBBLE_BASE + {6'h00, v};
	endfunction : nibTicks

	// one frame per trigger in triggered mode
	assign txStart = txState == sent_pkg::TX_IDLE && txOn && (!syncTransmit || triggerPending);
	assign lastTick = tickEn && tickCnt == intervalLen - 10'h001;

	// tick enable every count plus one clocks
	// start cycle is the first clock of the first tick, so the divider begins at one
	always_ff @(posedge clk) begin
		if (!reset_n || (txState == sent_pkg::TX_IDLE && !txStart)) begin
			tickDiv <= 16'h0000;
			tickEn <= 1'b0;
		end else if (txStart) begin
			tickDiv <= (tick_period_count == 16'h0000) ? 16'h0000 : 16'h0001;
			tickEn <= tick_period_count == 16'h0000;
		end else if (tickDiv == tick_period_count) begin
			tickDiv <= 16'h0000;
			tickEn <= 1'b1;
		end else begin
			tickDiv <= tickDiv + 16'h0001;
			tickEn <= 1'b0;
		end
	end

	// trigger seen in the start cycle is kept
	always_ff @(posedge clk) begin
		if (!reset_n || !txOn || !syncTransmit) begin
			triggerPending <= 1'b0;
		end else if (syncTrigger) begin
			triggerPending <= 1'b1;
		end else if (txStart) begin
			triggerPending <= 1'b0;
		end
	end

	// checksum interval still counts, pause is chosen while it ends
	assign doneTicks = usedTicks + {1'b0, intervalLen};

	// pause fills frame to frameTicks, clamped 12..768
	always_comb begin
		if ({5'h00, frameTicks} <= {10'h000, doneTicks} + {11'h000, sent_pkg::PAUSE_MIN}) begin
			pauseLen = sent_pkg::PAUSE_MIN;
		end else if (frameTicks - {5'h00, doneTicks} > {6'h00, sent_pkg::PAUSE_MAX}) begin
			pauseLen = sent_pkg::PAUSE_MAX;
		end else begin
			pauseLen = 10'(frameTicks - {5'h00, doneTicks});
		end
	end

	always_ff @(posedge clk) begin
		txCrcClear <= 1'b0;
		txCrcStep <= 1'b0;
		txFrameDone <= 1'b0;
		if (!reset_n || !txOn) begin
			txState <= sent_pkg::TX_IDLE;
			tickCnt <= 10'h000;
			intervalLen <= sent_pkg::SYNC_TICKS;
			usedTicks <= 11'h000;
			txIdx <= 3'h0;
			shadowStatus <= 4'h0;
			shadowData <= 24'h000000;
			shadowCrc <= 4'h0;
			txCrcNib <= 4'h0;
		end else if (txStart) begin
			// single-frame buffer latched at frame start
			shadowStatus <= txStatus;
			shadowData <= txData;
			shadowCrc <= txCrc;
			txCrcClear <= 1'b1;
			txState <= sent_pkg::TX_SYNC;
			intervalLen <= sent_pkg::SYNC_TICKS;
			tickCnt <= 10'h000;
			usedTicks <= 11'h000;
		end else if (tickEn && !lastTick) begin
			tickCnt <= tickCnt + 10'h001;
		end else if (lastTick) begin
			tickCnt <= 10'h000;
			usedTicks <= usedTicks + {1'b0, intervalLen};
			case (txState)
				sent_pkg::TX_SYNC: begin
					txState <= sent_pkg::TX_STATUS;
					intervalLen <= nibTicks(shadowStatus);
				end
				sent_pkg::TX_STATUS: begin
					txState <= sent_pkg::TX_DATA;
					txIdx <= 3'h0;
					intervalLen <= nibTicks(pickNibble(shadowData, 3'h0));
					txCrcStep <= 1'b1;
					txCrcNib <= pickNibble(shadowData, 3'h0);
				end
				sent_pkg::TX_DATA: begin
					if (txIdx == nibLast) begin
						txState <= sent_pkg::TX_CRC;
						intervalLen <= nibTicks(crcHardware ? crcBus.result : shadowCrc);
					end else begin
						txIdx <= txIdx + 3'h1;
						intervalLen <= nibTicks(pickNibble(shadowData, txIdx + 3'h1));
						txCrcStep <= 1'b1;
						txCrcNib <= pickNibble(shadowData, txIdx + 3'h1);
					end
				end
				sent_pkg::TX_CRC: begin
					if (pauseEnable) begin
						txState <= sent_pkg::TX_PAUSE;
						intervalLen <= pauseLen;
					end else begin
						txState <= sent_pkg::TX_IDLE;
						txFrameDone <= 1'b1;
					end
				end
				sent_pkg::TX_PAUSE: begin
					txState <= sent_pkg::TX_IDLE;
					txFrameDone <= 1'b1;
				end
				default: begin
					txState <= sent_pkg::TX_IDLE;
				end
			endcase
		end
	end

	// each interval opens with a falling edge, low for five ticks
	// abort releases the line at once, not one clock after the state
	always_ff @(posedge clk) begin
		if (!reset_n || !txOn) begin
			txLine <= 1'b1;
		end else begin
			txLine <= !(txState != sent_pkg::TX_IDLE && tickCnt < sent_pkg::LOW_TICKS);
		end
	end

	assign txBusy = txState != sent_pkg::TX_IDLE;

	// ---------------- receive ----------------
	sent_pkg::rx_state_t rxState;
	logic rxMeta;
	logic rxSync;
	logic rxPrev;
	logic fallEdge;
	logic [CNT_W-1:0] intervalCnt;
	logic [CNT_W-1:0] syncClocks;
	logic [CNT_W+5:0] nominalSync;
	logic [CNT_W+5:0] syncTol;
	logic [PW-1:0] scaledInterval;
	localparam int DEC_N = sent_pkg::DEC_THRESHOLDS;
	logic [DEC_N-1:0] aboveThr;
	logic [4:0] passCount;
	logic nibOk;
	logic [3:0] nibValue;
	logic syncOk;
	logic [2:0] rxIdx;
	logic [3:0] workStatus;
	logic [23:0] workData;
	logic rxCrcClear;
	logic rxCrcStep;
	logic [3:0] rxCrcNib;

	// two-stage synchroniser, edge seen after second stage
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			rxMeta <= 1'b1;
			rxSync <= 1'b1;
			rxPrev <= 1'b1;
		end else begin
			rxMeta <= rxLine;
			rxSync <= rxMeta;
			rxPrev <= rxSync;
		end
	end
	assign fallEdge = rxPrev && !rxSync;

	always_ff @(posedge clk) begin
		if (!reset_n || fallEdge) begin
			intervalCnt <= {{(CNT_W-1){1'b0}}, 1'b1};
		end else if (intervalCnt != {CNT_W{1'b1}}) begin
			intervalCnt <= intervalCnt + {{(CNT_W-1){1'b0}}, 1'b1};
		end
	end

	// sync window of nominal plus or minus tolerance
	assign nominalSync = (CNT_W+6)'({16'h0000, tick_period_count} + 32'h1) * (CNT_W+6)'(56);
	assign syncTol = (CNT_W+6)'((nominalSync * (CNT_W+6)'(sent_pkg::TOL_MUL)) >> sent_pkg::TOL_SHIFT);
	assign syncOk = (CNT_W+6)'(intervalCnt) >= nominalSync - syncTol
		&& (CNT_W+6)'(intervalCnt) <= nominalSync + syncTol;

	// decode against measured sync: interval*112 vs sync*(23+2k)
	assign scaledInterval = PW'(intervalCnt) * PW'(sent_pkg::DEC_SCALE);
	generate
		for (genvar k = 0; k < DEC_N; k++) begin : g_thr
			assign aboveThr[k] = scaledInterval >= PW'(syncClocks) * PW'(sent_pkg::DEC_BASE + 2 * k);
		end
	endgenerate

	always_comb begin
		passCount = 5'h00;
		for (int i = 0; i < DEC_N; i++) begin
			passCount = passCount + {4'h0, aboveThr[i]};
		end
	end
	// below 12 or above 27 ticks is invalid
	assign nibOk = passCount != 5'h00 && passCount != 5'(DEC_N);
	assign nibValue = 4'(passCount - 5'h01);

	always_ff @(posedge clk) begin
		rxCrcClear <= 1'b0;
		rxCrcStep <= 1'b0;
		rxDone <= 1'b0;
		rxCrcError <= 1'b0;
		rxFramingError <= 1'b0;
		if (!reset_n) begin
			rxState <= sent_pkg::RX_HUNT;
			syncClocks <= {CNT_W{1'b1}};
			rxSyncClocks <= {CNT_W{1'b0}};
			rxIdx <= 3'h0;
			workStatus <= 4'h0;
			workData <= 24'h000000;
			rxStatus <= 4'h0;
			rxData <= 24'h000000;
			rxCrc <= 4'h0;
			rxCrcNib <= 4'h0;
		end else if (!rxOn) begin
			rxState <= sent_pkg::RX_HUNT;
		end else if (fallEdge) begin
			case (rxState)
				sent_pkg::RX_HUNT: begin
					if (syncOk) begin
						syncClocks <= intervalCnt;
						rxState <= sent_pkg::RX_STATUS;
						rxCrcClear <= 1'b1;
					end
				end
				sent_pkg::RX_STATUS: begin
					if (nibOk) begin
						workStatus <= nibValue;
						rxIdx <= 3'h0;
						rxState <= sent_pkg::RX_DATA;
					end else begin
						rxFramingError <= 1'b1;
						rxState <= sent_pkg::RX_HUNT;
					end
				end
				sent_pkg::RX_DATA: begin
					if (nibOk) begin
						workData[4 * (5 - int'(rxIdx)) +: 4] <= nibValue;
						rxCrcStep <= 1'b1;
						rxCrcNib <= nibValue;
						rxIdx <= rxIdx + 3'h1;
						if (rxIdx == nibLast) begin
							rxState <= sent_pkg::RX_CRC;
						end
					end else begin
						rxFramingError <= 1'b1;
						rxState <= sent_pkg::RX_HUNT;
					end
				end
				sent_pkg::RX_CRC: begin
					if (nibOk) begin
						// publish the frame with a done pulse
						rxStatus <= workStatus;
						rxData <= workData;
						rxCrc <= nibValue;
						rxSyncClocks <= syncClocks;
						rxDone <= 1'b1;
						rxCrcError <= crcHardware && nibValue != crcBus.result;
						// skip the pause interval when configured
						rxState <= pauseEnable ? sent_pkg::RX_PAUSE : sent_pkg::RX_HUNT;
					end else begin
						rxFramingError <= 1'b1;
						rxState <= sent_pkg::RX_HUNT;
					end
				end
				sent_pkg::RX_PAUSE: begin
					rxState <= sent_pkg::RX_HUNT;
				end
				default: begin
					rxState <= sent_pkg::RX_HUNT;
				end
			endcase
		end
	end

	// checksum engine shared, roles never overlap
	always_comb begin
		crcBus.clear = receiveMode ? rxCrcClear : txCrcClear;
		crcBus.step = receiveMode ? rxCrcStep : txCrcStep;
		crcBus.nibble = receiveMode ? rxCrcNib : txCrcNib;
	end
endmodule : sent_nibble_link

`default_nettype wire

// *** shared/sent_pkg.sv ***
// constants and state types shared by the nibble link and its checksum engine
// assumes a single 40 MHz clock feeding every user of this package
`default_nettype none

package sent_pkg;
	// clock and tick-period range
	localparam int CLK_PERIOD_NS = 25;
	localparam int TICK_MIN_NS = 3000;
	localparam int TICK_MAX_NS = 90000;
	localparam int TICK_MIN_CYCLES = (TICK_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int TICK_MAX_CYCLES = TICK_MAX_NS / CLK_PERIOD_NS;

	// interval lengths, in ticks
	localparam int TICK_W = 10;
	localparam logic [9:0] SYNC_TICKS = 10'h038;
	localparam logic [9:0] NIBBLE_BASE = 10'h00c;
	localparam logic [9:0] LOW_TICKS = 10'h005;
	localparam logic [9:0] PAUSE_MIN = 10'h00c;
	localparam logic [9:0] PAUSE_MAX = 10'h300;

	// data nibbles per frame
	localparam logic [2:0] NIB_COUNT_MIN = 3'h3;
	localparam logic [2:0] NIB_COUNT_MAX = 3'h6;
	localparam int DATA_W = 24;

	// receive tolerance: 13/64 of nominal sync, just above 20 percent
	localparam logic [7:0] TOL_MUL = 8'h0d;
	localparam int TOL_SHIFT = 6;

	// decode: interval*112 against sync*(23+2k), k = 0..16
	localparam logic [6:0] DEC_SCALE = 7'h70;
	localparam int DEC_BASE = 23;
	localparam int DEC_THRESHOLDS = 17;

	// preferred checksum: seed and nibble step table
	localparam logic [3:0] CRC_SEED = 4'h5;
	localparam logic [3:0] CRC_TABLE [16] = '{
		4'h0, 4'hd, 4'h7, 4'ha, 4'he, 4'h3, 4'h9, 4'h4,
		4'h1, 4'hc, 4'h6, 4'hb, 4'hf, 4'h2, 4'h8, 4'h5
	};

	typedef enum {TX_IDLE, TX_SYNC, TX_STATUS, TX_DATA, TX_CRC, TX_PAUSE} tx_state_t;
	typedef enum {RX_HUNT, RX_STATUS, RX_DATA, RX_CRC, RX_PAUSE} rx_state_t;
endpackage : sent_pkg

`default_nettype wire

// *** shared/crc_step_if.sv ***
// carrier between the link sequencer and the checksum engine
// assumes both ends share one clock; all signals are synchronous to it
`default_nettype none

interface crc_step_if;
	logic clear;
	logic step;
	logic [3:0] nibble;
	logic [3:0] result;

	modport owner (output clear, output step, output nibble, input result);
	modport engine (input clear, input step, input nibble, output result);
endinterface : crc_step_if

`default_nettype wire

// *** rtl/nibble_crc.sv ***
// nibble-serial checksum engine, preferred method with one zero nibble appended
// assumes clear and step are never asserted together
`default_nettype none

module nibble_crc (
	// clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// step port
	crc_step_if.engine crcBus
);
	logic [3:0] crcState;

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			crcState <= sent_pkg::CRC_SEED;
		end else if (crcBus.clear) begin
			crcState <= sent_pkg::CRC_SEED;
		end else if (crcBus.step) begin
			crcState <= sent_pkg::CRC_TABLE[crcState] ^ crcBus.nibble;
		end
	end

	assign crcBus.result = sent_pkg::CRC_TABLE[crcState];
endmodule : nibble_crc

`default_nettype wire

// *** verification/sent_nibble_link_sva.sv ***
// assertions on the nibble link top ports
// assumes one clock, synchronous active-low reset
`default_nettype none

module sent_nibble_link_sva (
	// clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// configuration
	input wire logic enable,
	input wire logic receiveMode,
	input wire logic crcHardware,
	input wire logic [15:0] link_control_two,
	// watched outputs
	input wire logic txLine,
	input wire logic txBusy,
	input wire logic txFrameDone,
	input wire logic rxDone,
	input wire logic rxCrcError,
	input wire logic rxFramingError
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!reset_n);

	// low run of the line, in clocks
	logic [21:0] lowRun;
	always_ff @(posedge clk) begin
		if (!reset_n || txLine) lowRun <= 22'h0;
		else lowRun <= lowRun + 22'h1;
	end

	sequence startFall;
		txLine ##1 !txLine;
	endsequence

	a_start_line_fall: assert property ($rose(txBusy) |-> startFall)
		else $error("line did not fall one clock after busy rose");
	// abort leaves the line early, so only judged while enabled
	a_low_five_ticks: assert property ($rose(txLine) && enable |->
		lowRun == 22'(5 * (int'(link_control_two) + 1)))
		else $error("low part of interval is not five ticks");
	a_start_needs_tx: assert property ($rose(txBusy) |-> $past(enable) && !$past(receiveMode))
		else $error("frame started outside transmit operation");
	a_rx_mode_quiet: assert property (receiveMode && !txBusy |=> !txBusy)
		else $error("transmitter started in receive operation");
	a_done_closes_frame: assert property (txFrameDone |-> !txBusy && $past(txBusy))
		else $error("frame done without a frame in progress");
	a_tx_done_pulse: assert property (txFrameDone |=> !txFrameDone)
		else $error("frame done longer than one clock");
	a_rx_done_pulse: assert property (rxDone |=> !rxDone)
		else $error("receive done longer than one clock");
	a_crc_err_rule: assert property (rxCrcError |-> rxDone && crcHardware)
		else $error("checksum error outside a checked frame");
	a_framing_drops: assert property (rxFramingError |-> !rxDone)
		else $error("framing error frame was published");
	a_tx_mode_no_rx: assert property ((!receiveMode) [*4] |-> !rxDone && !rxFramingError)
		else $error("receive event in transmit operation");
	a_disable_idle: assert property (!enable |=> !txBusy && txLine)
		else $error("transmitter active while disabled");
endmodule : sent_nibble_link_sva

bind sent_nibble_link sent_nibble_link_sva checker_i (.clk(clk), .reset_n(reset_n),
	.enable(enable), .receiveMode(receiveMode), .crcHardware(crcHardware),
	.link_control_two(link_control_two), .txLine(txLine), .txBusy(txBusy),
	.txFrameDone(txFrameDone), .rxDone(rxDone), .rxCrcError(rxCrcError),
	.rxFramingError(rxFramingError));

`default_nettype wire

// *** verification/sent_sensor_model.sv ***
// sensor-side frame generator on the receive line
// assumes the caller enters send_frame right after a clock edge
`default_nettype none

module sent_sensor_model (
	// clock
	input wire logic clk,
	// line, idles high as behind a pull-up
	output var logic line
);
	timeunit 1ns;
	timeprecision 100ps;
	initial line = 1'b1;

	// one fall per interval, tk clocks per tick
	task automatic emit(input int tk, input int ticks);
		line <= 1'b0;
		repeat (5 * tk) @(posedge clk);
		line <= 1'b1;
		repeat ((ticks - 5) * tk) @(posedge clk);
	endtask : emit

	// sync, status, six data, checksum, closing fall
	task automatic send_frame(input int tk, input logic [3:0] st, input logic [23:0] dat,
			input logic [3:0] crc, input int extra);
		@(posedge clk);
		emit(tk, 56);
		emit(tk, 12 + st);
		for (int k = 0; k < 6; k++) begin
			emit(tk, 12 + dat[4*(5-k)+:4] + (k == 0 ? extra : 0));
		end
		emit(tk, 12 + crc);
		line <= 1'b0;
		repeat (5 * tk) @(posedge clk);
		line <= 1'b1;
	endtask : send_frame
endmodule : sent_sensor_model

`default_nettype wire

// *** verification/sent_nibble_link_bench.sv ***
// self-checking bench: transmit frames measured on txLine, receive via sensor model
// assumes tick of ten clocks (count 9) to keep the run short
`default_nettype none

module sent_nibble_link_bench;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk, reset_n, enable, receiveMode, syncTransmit, crcHardware, pauseEnable;
	logic [2:0] nibbleCount;
	logic [15:0] link_control_two, frameTicks;
	logic [3:0] txStatus, txCrc, rxStatus, rxCrc;
	logic [23:0] txData, rxData;
	logic [21:0] rxSyncClocks;
	logic syncTrigger, txLine, txBusy, txFrameDone, rxLine, rxDone, rxCrcError, rxFramingError;
	logic prevLine = 1'b1;
	logic seenFall = 1'b0;
	int n_mismatch = 0, total_checks = 0, cycles = 0, gapCnt = 0;
	int nDone = 0, nCrcErr = 0, nFrmErr = 0, nTxDone = 0;
	int gaps[$];

	sent_nibble_link DUT (.clk(clk), .reset_n(reset_n), .enable(enable),
		.receiveMode(receiveMode), .syncTransmit(syncTransmit), .crcHardware(crcHardware),
		.pauseEnable(pauseEnable), .nibbleCount(nibbleCount),
		.link_control_two(link_control_two), .frameTicks(frameTicks), .txStatus(txStatus),
		.txData(txData), .txCrc(txCrc), .syncTrigger(syncTrigger), .txLine(txLine),
		.txBusy(txBusy), .txFrameDone(txFrameDone), .rxLine(rxLine), .rxStatus(rxStatus),
		.rxData(rxData), .rxCrc(rxCrc), .rxSyncClocks(rxSyncClocks), .rxDone(rxDone),
		.rxCrcError(rxCrcError), .rxFramingError(rxFramingError));
	sent_sensor_model SENSOR (.clk(clk), .line(rxLine));

	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	task automatic wrap_up();
		$display("checks=%0d mismatches=%0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : wrap_up

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : check

	function automatic logic [3:0] crc_of(input logic [23:0] d, input int n);
		logic [3:0] c;
		c = sent_pkg::CRC_SEED;
		for (int k = 0; k < n; k++) begin
			c = sent_pkg::CRC_TABLE[c] ^ d[4*(5-k)+:4];
		end
		return sent_pkg::CRC_TABLE[c];
	endfunction : crc_of

	// interval between falls of txLine, and event counts
	always @(posedge clk) begin
		cycles <= cycles + 1;
		prevLine <= txLine;
		gapCnt <= gapCnt + 1;
		if (prevLine && !txLine) begin
			if (seenFall) gaps.push_back(gapCnt);
			seenFall <= 1'b1;
			gapCnt <= 1;
		end
		nDone <= nDone + int'(rxDone);
		nCrcErr <= nCrcErr + int'(rxCrcError);
		nFrmErr <= nFrmErr + int'(rxFramingError);
		nTxDone <= nTxDone + int'(txFrameDone);
		if (cycles > 80000) begin
			n_mismatch++;
			wrap_up();
		end
	end

	task automatic tx_frame(input int n, input logic hw);
		int ex[$];
		int t;
		t = 0;
		@(posedge clk);
		nibbleCount <= 3'(n);
		crcHardware <= hw;
		@(posedge clk);
		gaps.delete();
		seenFall <= 1'b0;
		syncTrigger <= 1'b1;
		@(posedge clk);
		syncTrigger <= 1'b0;
		while (!txFrameDone && t < 6000) begin
			@(posedge clk);
			t++;
		end
		ex = {56, 12 + txStatus};
		for (int k = 0; k < n; k++) begin
			ex.push_back(12 + txData[4*(5-k)+:4]);
		end
		ex.push_back(12 + (hw ? crc_of(txData, n) : txCrc));
		check(32'(t < 6000), 32'h1);
		check(32'(t), 32'(frameTicks) * 32'd10 + 32'd2);
		check(32'(gaps.size()), 32'(n + 3));
		foreach (ex[i]) check(32'(gaps[i]), 32'(ex[i] * 10));
	endtask : tx_frame

	task automatic rx_frame(input int tk, input logic [3:0] crc, input int extra,
			input int eDone, input int eCrc, input int eFrm);
		int d0, c0, f0;
		d0 = nDone;
		c0 = nCrcErr;
		f0 = nFrmErr;
		SENSOR.send_frame(tk, 4'h3, 24'h8d27f1, crc, extra);
		repeat (20) @(posedge clk);
		check(32'(nDone - d0), 32'(eDone));
		check(32'(nCrcErr - c0), 32'(eCrc));
		check(32'(nFrmErr - f0), 32'(eFrm));
	endtask : rx_frame

	initial begin
		int t;
		reset_n = 1'b0;
		enable = 1'b0;
		receiveMode = 1'b0;
		syncTransmit = 1'b1;
		crcHardware = 1'b1;
		pauseEnable = 1'b1;
		nibbleCount = 3'h6;
		link_control_two = 16'h0009;
		frameTicks = 16'h0190;
		txStatus = 4'h7;
		txData = 24'hc4e19b;
		txCrc = 4'h9;
		syncTrigger = 1'b0;
		repeat (4) @(posedge clk);
		reset_n <= 1'b1;
		@(posedge clk);
		enable <= 1'b1;
		@(posedge clk);
		check({31'h0, txLine}, 32'h1);
		check({31'h0, txBusy}, 32'h0);
		check({8'h0, rxData}, 32'h0);
		// every data count, checksum from hardware and from software
		for (int n = 3; n <= 6; n++) tx_frame(n, n[0] == 1'b0);
		@(posedge clk);
		syncTransmit <= 1'b0;
		nibbleCount <= 3'h3;
		t = nTxDone;
		repeat (2) @(posedge clk);
		while (nTxDone < t + 2 && cycles < 70000) @(posedge clk);
		check(32'(nTxDone - t >= 2), 32'h1);
		enable <= 1'b0;
		repeat (2) @(posedge clk);
		check({31'h0, txBusy}, 32'h0);
		receiveMode <= 1'b1;
		enable <= 1'b1;
		crcHardware <= 1'b1;
		pauseEnable <= 1'b0;
		nibbleCount <= 3'h6;
		repeat (50) @(posedge clk);
		rx_frame(11, crc_of(24'h8d27f1, 6), 0, 1, 0, 0);
		check({28'h0, rxStatus}, 32'h3);
		check({8'h0, rxData}, 32'h008d27f1);
		check({28'h0, rxCrc}, 32'(crc_of(24'h8d27f1, 6)));
		check({10'h0, rxSyncClocks}, 32'(56 * 11));
		pauseEnable <= 1'b1;
		rx_frame(9, crc_of(24'h8d27f1, 6) ^ 4'h1, 0, 1, 1, 0);
		rx_frame(11, crc_of(24'h8d27f1, 6), 16, 0, 0, 1);
		rx_frame(13, crc_of(24'h8d27f1, 6), 0, 0, 0, 0);
		wrap_up();
	end
endmodule : sent_nibble_link_bench

`default_nettype wire
